// >>> remote_control_front_end_test.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module remote_control_front_end_test
  import remote_front_end_pkg::*;
;
  localparam int BITC = 16; // Short bit time for simulation
  localparam int DEB = 4; // Short debounce
  localparam int MSG = 8; // Short message time
  localparam int LIMIT = 10000; // Whole run fits well inside this
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic contact_remote_enable = 1'b0;
  logic start_button = 1'b0;
  logic reset_button = 1'b0;
  logic error_active = 1'b0;
  logic onoff_contact = 1'b0;
  logic select_one_contact = 1'b0;
  logic select_two_contact = 1'b0;
  logic rxd;
  logic txd, local_start, start_lockout, remote_lockout_message, alarm;
  logic program_start, program_stop, system_reset, cmd_valid;
  logic [1:0] selected_slot;
  logic [5:0] cmd_len;
  logic [255:0] cmd_string;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0; // Cycle count for the timeout
  int starts = 0, stops = 0, resets = 0, cmds = 0; // Pulse tallies
  logic [15:0] last_len, last_str; // Latched at each completed command
  always #2.5 clk = ~clk; // 200 MHz
  ////////////////////////////////////////////////////////////////////////////////
  remote_front_end #(.BIT_CYCLES(BITC), .DEBOUNCE_CYCLES(DEB), .MESSAGE_CYCLES(MSG)) dut (
    .clk(clk), .srst(srst), .contact_remote_enable(contact_remote_enable),
    .start_button(start_button), .reset_button(reset_button), .error_active(error_active),
    .onoff_contact(onoff_contact), .select_one_contact(select_one_contact),
    .select_two_contact(select_two_contact), .rxd(rxd), .txd(txd),
    .local_start(local_start), .start_lockout(start_lockout),
    .remote_lockout_message(remote_lockout_message), .alarm(alarm),
    .program_start(program_start), .program_stop(program_stop),
    .selected_slot(selected_slot), .system_reset(system_reset), .cmd_valid(cmd_valid),
    .cmd_len(cmd_len), .cmd_string(cmd_string)
  );
  remote_host_model #(.BIT_CYCLES(BITC)) host (.clk(clk), .host_rxd(txd), .host_txd(rxd));
  ////////////////////////////////////////////////////////////////////////////////
  // Tally one-cycle pulses; they are too short to poll from a scenario
  always @(posedge clk) begin
    cyc++;
    if (program_start === 1'b1) starts++;
    if (program_stop === 1'b1) stops++;
    if (system_reset === 1'b1) resets++;
    if (cmd_valid === 1'b1) begin
      cmds++;
      last_len = {10'h000, cmd_len};
      last_str = cmd_string[15:0];
    end
    // A hang counts as a mismatch
    if (cyc >= LIMIT) begin
      fail_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Step n edges, then 1 ns so inputs never change on the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec
  // Bounded wait for the next byte from the device
  task automatic expect_echo(input byte_t exp);
    for (int k = 0; k < 400 && host.rx_q.size() == 0; k++) tick(1);
    if (host.rx_q.size() == 0) chk_vec("echo present", 16'h0001, 16'h0000);
    else chk_vec("echo byte", {8'h00, exp}, {8'h00, host.rx_q.pop_front()});
  endtask : expect_echo
  ////////////////////////////////////////////////////////////////////////////////
  // Closures while remote is off are ignored
  task automatic t_disabled();
    {select_two_contact, select_one_contact} = 2'b10;
    onoff_contact = 1'b1;
    tick(12);
    {select_two_contact, select_one_contact} = 2'b00;
    onoff_contact = 1'b0;
    tick(12);
    chk_vec("slot", 16'h0001, {14'h0, selected_slot});
    chk_vec("starts", 16'h0000, starts[15:0]);
    chk_vec("stops", 16'h0000, stops[15:0]);
  endtask : t_disabled
  // Panel start passes when unlocked, is refused with message when locked
  task automatic t_panel();
    start_button = 1'b1;
    tick(1);
    start_button = 1'b0;
    chk_bit("local_start", 1'b1, local_start);
    contact_remote_enable = 1'b1;
    tick(2);
    chk_bit("start_lockout", 1'b1, start_lockout);
    start_button = 1'b1;
    tick(1);
    start_button = 1'b0;
    chk_bit("local_start", 1'b0, local_start);
    chk_bit("message", 1'b1, remote_lockout_message);
    chk_bit("alarm", 1'b1, alarm);
    tick(MSG - 2);
    chk_bit("message", 1'b1, remote_lockout_message);
    tick(5);
    chk_bit("message", 1'b0, remote_lockout_message);
    chk_bit("alarm", 1'b0, alarm);
    chk_vec("starts", 16'h0000, starts[15:0]);
  endtask : t_panel
  // Every select code, then run and stop the chosen program
  task automatic t_select();
    logic [1:0] codes [3] = '{2'b01, 2'b10, 2'b11};
    for (int i = 0; i < 3; i++) begin
      {select_two_contact, select_one_contact} = codes[i];
      tick(12);
      {select_two_contact, select_one_contact} = 2'b00;
      tick(12);
      chk_vec("slot", 16'(i + 1), {14'h0, selected_slot});
    end
    onoff_contact = 1'b1;
    tick(12);
    chk_vec("starts", 16'h0001, starts[15:0]);
    onoff_contact = 1'b0;
    tick(12);
    chk_vec("stops", 16'h0001, stops[15:0]);
  endtask : t_select
  // Error cleared by panel reset or by the on/off contact
  task automatic t_error();
    error_active = 1'b1;
    reset_button = 1'b1;
    tick(1);
    reset_button = 1'b0;
    chk_bit("system_reset", 1'b1, system_reset);
    onoff_contact = 1'b1;
    tick(12);
    chk_vec("resets", 16'h0002, resets[15:0]);
    chk_vec("starts", 16'h0001, starts[15:0]);
    error_active = 1'b0;
    reset_button = 1'b1;
    tick(1);
    reset_button = 1'b0;
    tick(2);
    chk_vec("resets", 16'h0002, resets[15:0]);
    onoff_contact = 1'b0;
    tick(12);
  endtask : t_error
  // Back-to-back command with terminator, then rejected characters
  task automatic t_serial();
    host.send_byte(8'h54, 1'b1);
    host.send_byte(8'h53, 1'b1);
    host.send_byte(8'h0a, 1'b1);
    expect_echo(8'h54);
    expect_echo(8'h53);
    expect_echo(8'h0a);
    chk_vec("cmds", 16'h0001, cmds[15:0]);
    chk_vec("cmd_len", 16'h0002, last_len);
    chk_vec("cmd_string", 16'h5354, last_str);
    host.send_byte(8'h80, 1'b1);
    expect_echo(8'h15);
    host.send_byte(8'h41, 1'b0);
    expect_echo(8'h15);
    tick(2 * BITC);
    host.send_byte(8'h0a, 1'b1);
    expect_echo(8'h0a);
    chk_vec("cmd_len", 16'h0000, last_len);
  endtask : t_serial
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    srst = 1'b0;
    tick(1);
    chk_bit("txd idle", 1'b1, txd);
    chk_vec("slot", 16'h0001, {14'h0, selected_slot});
    t_disabled();
    t_panel();
    t_select();
    t_error();
    t_serial();
    finish_test();
  end
endmodule : remote_control_front_end_test
`default_nettype wire

// >>> remote_front_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "remote_front_end_defines.svh"
module remote_front_end
  import remote_front_end_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = `BIT_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int unsigned MESSAGE_CYCLES = `MESSAGE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic contact_remote_enable,
  input wire logic start_button,
  input wire logic reset_button,
  input wire logic error_active,
  input wire logic onoff_contact,
  input wire logic select_one_contact,
  input wire logic select_two_contact,
  input wire logic rxd,
  output logic txd,
  output logic local_start,
  output logic start_lockout,
  output logic remote_lockout_message,
  output logic alarm,
  output logic program_start,
  output logic program_stop,
  output logic [1:0] selected_slot,
  output logic system_reset,
  output logic cmd_valid,
  output logic [`CMD_LEN_W-1:0] cmd_len,
  output logic [8*`CMD_DEPTH-1:0] cmd_string
);

  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;

  // Select contacts to slot code; both closed means slot three
  function automatic logic [1:0] slot_of(input logic [1:0] sel);
    slot_of = (sel == 2'h3) ? `SLOT_THREE : ((sel == 2'h2) ? `SLOT_TWO : `SLOT_ONE);
  endfunction : slot_of

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and debouncers
  //////////////////////////////////////////////////////////////////////////////
  logic [3:0] sync1_reg; // First stage, read only by second
  logic [3:0] sync2_reg; // Clean copies
  logic [2:0] db_vec; // Debounced contacts: {sel2, sel1, onoff}

  // Two flops on the receive line and the three contact lines
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_reg <= `SYNC_RST;
      sync2_reg <= `SYNC_RST;
    end else begin
      sync1_reg <= {rxd, select_two_contact, select_one_contact, onoff_contact}; // RULE16
      sync2_reg <= sync1_reg;
    end
  end

  // Dry contacts bounce for milliseconds; require a stable level first
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_db
      logic db_reg;
      logic db_next;
      logic [31:0] cnt_reg;
      logic [31:0] cnt_next;
      // Count while the line disagrees with the accepted level
      always_comb begin
        db_next = db_reg;
        cnt_next = 32'h0;
        if (sync2_reg[gi] != db_reg) begin
          if (cnt_reg >= DEBOUNCE_CYCLES - 1) begin
            db_next = sync2_reg[gi]; // RULE16
          end else begin
            cnt_next = cnt_reg + 32'h1;
          end
        end
      end
      always_ff @(posedge clk) begin
        if (srst) begin
          db_reg <= 1'b0;
          cnt_reg <= 32'h0;
        end else begin
          db_reg <= db_next;
          cnt_reg <= cnt_next;
        end
      end
      assign db_vec[gi] = db_reg;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Contact-closure control
  //////////////////////////////////////////////////////////////////////////////
  logic [2:0] db_prev_reg; // Previous debounced levels
  logic [1:0] slot_reg, slot_next; // Latched program slot
  logic start_reg, start_next;
  logic stop_reg, stop_next;
  logic sreset_reg, sreset_next;
  logic local_reg, local_next;
  logic lockout_reg, lockout_next;
  logic onoff_rise, onoff_fall, sel_rise;

  assign onoff_rise = db_vec[0] & ~db_prev_reg[0];
  assign onoff_fall = ~db_vec[0] & db_prev_reg[0];
  assign sel_rise = |(db_vec[2:1] & ~db_prev_reg[2:1]);

  // Next values of the contact outputs
  always_comb begin
    slot_next = slot_reg;
    start_next = 1'b0;
    stop_next = 1'b0;
    // Select and on/off closures count only with remote enabled
    if (contact_remote_enable) begin // RULE1
      // Latch on a closing edge; a late second contact upgrades to three
      if (sel_rise) begin
        slot_next = slot_of(db_vec[2:1]); // RULE6
      end
      // Maintained contact: close runs, open stops; not during an error
      if (!error_active) begin
        start_next = onoff_rise; // RULE5
        stop_next = onoff_fall; // RULE5
      end
    end
    // Error clears by panel reset or by operating the on/off contact
    sreset_next = error_active &
      (reset_button | (contact_remote_enable & (onoff_rise | onoff_fall))); // RULE4
    // Panel start passes only while remote enable is off
    local_next = start_button & ~contact_remote_enable; // RULE2
    lockout_next = contact_remote_enable; // RULE2
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      db_prev_reg <= 3'h0;
      slot_reg <= `SLOT_ONE;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      sreset_reg <= 1'b0;
      local_reg <= 1'b0;
      lockout_reg <= 1'b0;
    end else begin
      db_prev_reg <= db_vec;
      slot_reg <= slot_next;
      start_reg <= start_next;
      stop_reg <= stop_next;
      sreset_reg <= sreset_next;
      local_reg <= local_next;
      lockout_reg <= lockout_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lockout message and alarm
  //////////////////////////////////////////////////////////////////////////////
  logic msg_reg, msg_next;
  logic [31:0] msg_cnt_reg, msg_cnt_next;

  // A locked press only shows the message; nothing else changes state
  always_comb begin
    msg_next = msg_reg;
    msg_cnt_next = msg_cnt_reg;
    if (start_button && contact_remote_enable) begin
      msg_next = 1'b1; // RULE3
      msg_cnt_next = 32'h0;
    end else if (msg_reg) begin
      if (msg_cnt_reg >= MESSAGE_CYCLES - 1) begin
        msg_next = 1'b0; // RULE3
      end else begin
        msg_cnt_next = msg_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      msg_reg <= 1'b0;
      msg_cnt_reg <= 32'h0;
    end else begin
      msg_reg <= msg_next;
      msg_cnt_reg <= msg_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial receiver
  //////////////////////////////////////////////////////////////////////////////
  rx_state_t rx_state_reg, rx_state_next;
  logic [31:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] rx_idx_reg, rx_idx_next;
  byte_t rx_shift_reg, rx_shift_next;
  byte_t rx_byte_reg, rx_byte_next;
  logic rx_done_reg, rx_done_next; // One-cycle pulse per character
  logic rx_ferr_reg, rx_ferr_next; // Stop bit was low
  logic rxs;

  assign rxs = sync2_reg[3];

  // Sample mid-bit; no modem lines are looked at
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg + 32'h1;
    rx_idx_next = rx_idx_reg;
    rx_shift_next = rx_shift_reg;
    rx_byte_next = rx_byte_reg;
    rx_done_next = 1'b0;
    rx_ferr_next = rx_ferr_reg;
    case (rx_state_reg)
      RX_IDLE: begin
        rx_cnt_next = 32'h0;
        if (!rxs) begin
          rx_state_next = RX_START;
        end
      end
      RX_START: begin
        // A glitch shorter than half a bit is not a start bit
        if (rx_cnt_reg >= HALF_CYCLES - 1) begin
          rx_cnt_next = 32'h0;
          rx_idx_next = 3'h0;
          rx_state_next = rxs ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_cnt_reg >= BIT_CYCLES - 1) begin
          rx_cnt_next = 32'h0;
          rx_shift_next = {rxs, rx_shift_reg[7:1]}; // RULE7
          rx_idx_next = rx_idx_reg + 3'h1;
          if (rx_idx_reg == `DATA_BITS) begin
            rx_state_next = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt_reg >= BIT_CYCLES - 1) begin
          rx_byte_next = rx_shift_reg;
          rx_ferr_next = ~rxs; // RULE7
          rx_done_next = 1'b1;
          rx_state_next = RX_IDLE;
        end
      end
      default: rx_state_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 32'h0;
      rx_idx_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_byte_reg <= 8'h00;
      rx_done_reg <= 1'b0;
      rx_ferr_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_idx_reg <= rx_idx_next;
      rx_shift_reg <= rx_shift_next;
      rx_byte_reg <= rx_byte_next;
      rx_done_reg <= rx_done_next;
      rx_ferr_reg <= rx_ferr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Accept decision and command buffer
  //////////////////////////////////////////////////////////////////////////////
  byte_t mem_reg [`CMD_DEPTH];
  byte_t mem_next [`CMD_DEPTH];
  logic [`CMD_LEN_W-1:0] len_reg, len_next; // Characters held
  logic [`CMD_LEN_W-1:0] out_len_reg, out_len_next;
  logic valid_reg, valid_next;
  logic accept; // Framing, overflow and non-ASCII are rejected
  logic is_lf;

  assign is_lf = (rx_byte_reg == `CHAR_LF);
  assign accept = ~rx_ferr_reg & (is_lf |
    ((rx_byte_reg < `CHAR_ASCII_TOP) && (len_reg < `CMD_DEPTH))); // RULE9

  // Store accepted text; line feed hands the string over and empties
  always_comb begin
    mem_next = mem_reg;
    len_next = len_reg;
    out_len_next = out_len_reg;
    valid_next = 1'b0;
    if (rx_done_reg && accept) begin
      if (is_lf) begin
        valid_next = 1'b1; // RULE15
        out_len_next = len_reg;
        len_next = '0;
      end else begin
        mem_next[len_reg[`CMD_LEN_W-2:0]] = rx_byte_reg; // RULE15
        len_next = len_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `CMD_DEPTH; i++) begin
        mem_reg[i] <= 8'h00;
      end
      len_reg <= '0;
      out_len_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      len_reg <= len_next;
      out_len_reg <= out_len_next;
      valid_reg <= valid_next;
    end
  end

  generate
    for (gi = 0; gi < `CMD_DEPTH; gi++) begin : g_flat
      assign cmd_string[8*gi +: 8] = mem_reg[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Serial transmitter: echo or refusal
  //////////////////////////////////////////////////////////////////////////////
  tx_state_t tx_state_reg, tx_state_next;
  logic [31:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_idx_reg, tx_idx_next;
  logic [9:0] tx_shift_reg, tx_shift_next;
  logic pend_reg, pend_next; // One character waiting to go out
  byte_t pend_byte_reg, pend_byte_next;
  logic txd_reg, txd_next;

  // Sends without waiting on anything; one holding slot covers a
  // character arriving while the previous answer is still going out
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg + 32'h1;
    tx_idx_next = tx_idx_reg;
    tx_shift_next = tx_shift_reg;
    pend_next = pend_reg;
    pend_byte_next = pend_byte_reg;
    case (tx_state_reg)
      TX_IDLE: begin
        tx_cnt_next = 32'h0;
        if (pend_reg) begin // RULE8
          tx_shift_next = {1'b1, pend_byte_reg, 1'b0}; // RULE7
          tx_idx_next = 4'h0;
          pend_next = 1'b0;
          tx_state_next = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tx_cnt_reg >= BIT_CYCLES - 1) begin
          tx_cnt_next = 32'h0;
          tx_shift_next = {1'b1, tx_shift_reg[9:1]};
          tx_idx_next = tx_idx_reg + 4'h1;
          if (tx_idx_reg == `FRAME_LAST) begin
            tx_state_next = TX_IDLE;
          end
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
    // New answer wins over the slot being emptied
    if (rx_done_reg) begin
      pend_next = 1'b1;
      pend_byte_next = accept ? rx_byte_reg : `CHAR_NAK; // RULE10 RULE11
    end
    txd_next = (tx_state_next == TX_SHIFT) ? tx_shift_next[0] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 32'h0;
      tx_idx_reg <= 4'h0;
      tx_shift_reg <= 10'h3ff;
      pend_reg <= 1'b0;
      pend_byte_reg <= 8'h00;
      txd_reg <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_idx_reg <= tx_idx_next;
      tx_shift_reg <= tx_shift_next;
      pend_reg <= pend_next;
      pend_byte_reg <= pend_byte_next;
      txd_reg <= txd_next;
    end
  end

  // Outputs from flops
  assign txd = txd_reg; // RULE13
  assign local_start = local_reg;
  assign start_lockout = lockout_reg;
  assign remote_lockout_message = msg_reg;
  assign alarm = msg_reg;
  assign program_start = start_reg;
  assign program_stop = stop_reg;
  assign selected_slot = slot_reg;
  assign system_reset = sreset_reg;
  assign cmd_valid = valid_reg;
  assign cmd_len = out_len_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_locked_press;
    start_button && contact_remote_enable;
  endsequence
  sequence s_ok_char;
    rx_done_reg && accept && tx_state_reg == TX_IDLE && !pend_reg;
  endsequence

  a_disabled_quiet: assert property (!$past(contact_remote_enable) |-> !program_start && !program_stop) else $error("closure acted while disabled"); // RULE1
  a_start_locked: assert property ($past(contact_remote_enable) |-> !local_start && start_lockout) else $error("panel start not locked"); // RULE2
  a_lock_message: assert property (s_locked_press |=> remote_lockout_message && alarm && !program_start) else $error("no lockout message"); // RULE3
  a_error_reset: assert property (error_active && reset_button |=> system_reset) else $error("error not reset"); // RULE4
  a_start_edge: assert property (program_start |-> $past(onoff_rise) && $past(contact_remote_enable)) else $error("start without closure"); // RULE5
  a_slot_select: assert property (contact_remote_enable && sel_rise |=> selected_slot == slot_of($past(db_vec[2:1]))) else $error("wrong slot"); // RULE6
  a_tx_idle_high: assert property (tx_state_reg == TX_IDLE |-> txd) else $error("line not idle high"); // RULE7
  a_echo_byte: assert property (s_ok_char |-> ##2 tx_shift_reg[8:1] == $past(rx_byte_reg, 2) && !txd) else $error("echo differs"); // RULE10
  a_nak_byte: assert property (rx_done_reg && !accept |=> pend_reg && pend_byte_reg == `CHAR_NAK) else $error("no refusal byte"); // RULE11
  a_lf_handover: assert property (rx_done_reg && accept && is_lf |=> cmd_valid && len_reg == '0) else $error("line feed not handed over"); // RULE15
  a_debounce_hold: assert property (db_vec[0] != $past(db_vec[0]) |-> $past(sync2_reg[0], 1) == db_vec[0] && $past(sync2_reg[0], 2) == db_vec[0]) else $error("debounce took unstable level"); // RULE16

endmodule : remote_front_end
`default_nettype wire

// >>> remote_front_end_defines.svh
// Notes on behaviour
// RULE1: Contact inputs ignored unless remote enable on
// RULE2: Remote enable disables local start button
// RULE3: Locked start press: message, alarm, no change
// RULE4: After error, reset button or on/off resets
// RULE5: On/off contact starts or stops selected program
// RULE6: Select one, two, or both gives slot three
// RULE7: Serial framing 9600 baud, 8N1
// RULE8: No handshake lines; never wait before sending
// RULE9: Every received character accepted or rejected
// RULE10: Accepted characters echoed back unchanged
// RULE11: Errors answered with single byte 15h
// RULE12: Host ends each command with 0Ah
// RULE13: Three wires only: receive, transmit, ground
// RULE14: Host crosses transmit and receive lines
// RULE15: Buffer characters, hand over on line feed
// RULE16: Debounce, synchronise, latch select on edge
`ifndef REMOTE_FRONT_END_DEFINES_SVH
`define REMOTE_FRONT_END_DEFINES_SVH
// Clock rate and timing figures in their own units
`define CLK_HZ 200000000
`define BAUD_RATE 9600
`define DEBOUNCE_MS 10
`define MESSAGE_MS 1000
// Derived cycle counts, rounded down
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define DEBOUNCE_CYCLES ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define MESSAGE_CYCLES ((`CLK_HZ / 1000) * `MESSAGE_MS)
// Character codes
`define CHAR_LF 8'h0a
`define CHAR_NAK 8'h15
`define CHAR_ASCII_TOP 8'h80
// Command buffer
`define CMD_DEPTH 32
`define CMD_LEN_W 6
// Slot codes
`define SLOT_ONE 2'h1
`define SLOT_TWO 2'h2
`define SLOT_THREE 2'h3
// Reset value of the synchroniser: line idle high, contacts open
`define SYNC_RST 4'h8
// Serial frame: start, eight data, stop
`define DATA_BITS 3'h7
`define FRAME_LAST 4'h9
`endif

// >>> remote_front_end_pkg.sv
package remote_front_end_pkg;
  // Receive sequencer states
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;
  // Transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;
  typedef logic [7:0] byte_t;
endpackage : remote_front_end_pkg

// >>> remote_host_model.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host end of the command link: three wires, no modem-control lines
module remote_host_model
  import remote_front_end_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic host_rxd, // Fed by the device transmit line
  output logic host_txd // Drives the device receive line
);
  byte_t rx_q[$]; // Bytes heard from the device
  byte_t rx_b; // Byte being assembled
  initial host_txd = 1'b1; // Line idles at mark
  ////////////////////////////////////////////////////////////////////////////////
  // One frame, start bit then LSB first; stop level is chosen so a fault can be
  // made on purpose. Sends at once, never waits on the far side.
  task automatic send_byte(input byte_t b, input logic stop_bit);
    logic [9:0] frame;
    frame = {stop_bit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_txd = frame[i];
      repeat (BIT_CYCLES) @(posedge clk);
      #1;
    end
    // A good frame already ends at mark, so the next frame may start at once;
    // a low stop bit gets one idle bit so the next start bit begins from mark
    if (!stop_bit) begin
      host_txd = 1'b1;
      repeat (BIT_CYCLES) @(posedge clk);
      #1;
    end
  endtask : send_byte
  ////////////////////////////////////////////////////////////////////////////////
  // Receiver: sample mid-bit, 8 data bits LSB first
  initial begin
    forever begin
      @(negedge host_rxd);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge clk);
        rx_b[i] = host_rxd;
      end
      // Wait out the stop bit before hunting the next start
      repeat (BIT_CYCLES) @(posedge clk);
      rx_q.push_back(rx_b);
    end
  end
endmodule : remote_host_model
`default_nettype wire
